// *** rtl/sfc_pkg.sv ***
// Shared constants and types for the spatial filter control block
package sfc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the Wishbone bus)
    // ------------------------------------------------------------
    localparam logic [31:0] SFC_SETUP_ADDR  = 32'h0000_0500;
    localparam logic [31:0] SFC_STATUS_ADDR = 32'h0000_0504;

    // Setup register reset value and writable-bit mask
    localparam logic [31:0] SFC_SETUP_RST   = 32'h0000_0000;
    localparam logic [31:0] SFC_SETUP_WMASK = 32'hf0ff_7fff;
    localparam logic [31:0] SFC_RESV_MASK   = 32'h0f00_8000;

    // Field positions inside the setup word
    localparam int SFC_ARR_TAP_LSB  = 0;
    localparam int SFC_PRE_TAP_LSB  = 8;
    localparam int SFC_ROUTE_LSB    = 16;
    localparam int SFC_PRE_BYP_BIT  = 28;
    localparam int SFC_ARR_BYP_BIT  = 29;
    localparam int SFC_PRE_EN_BIT   = 30;
    localparam int SFC_ARR_EN_BIT   = 31;

    // Stage sizes
    localparam int SFC_ARR_TAP_W    = 8;
    localparam int SFC_PRE_TAP_W    = 7;
    localparam int SFC_HIST_DEPTH   = 256;
    localparam int SFC_CHANNELS     = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic signed [15:0] sfc_sample_t;

    typedef struct packed {
        sfc_sample_t [SFC_CHANNELS-1:0] ch;
    } sfc_quad_t;

    typedef struct packed {
        logic       arr_enable;
        logic       pre_enable;
        logic       arr_bypass;
        logic       pre_bypass;
        logic [3:0] spare_hi;
        logic [1:0] out_d_route_pick;
        logic [1:0] out_c_route_pick;
        logic [1:0] out_b_route_pick;
        logic [1:0] out_a_route_pick;
        logic       spare_lo;
        logic [6:0] pre_tap;
        logic [7:0] arr_tap;
    } sfc_setup_t;

    typedef struct packed {
        logic [15:0] out_count;
        logic [7:0]  drop_count;
        logic [3:0]  spare;
        logic        engine_bypassed;
        logic        engine_on;
        logic        arr_busy;
        logic        pre_busy;
    } sfc_status_t;

    typedef enum logic {
        SFC_ST_IDLE,
        SFC_ST_RUN
    } sfc_stage_st_t;

endpackage

// *** rtl/sfc_tap_stage.sv ***
// One filter stage: history memory, tap walk, bypass and mute paths
`timescale 1ns/10ps
`default_nettype none
module sfc_tap_stage
    import sfc_pkg::*;
#(
    parameter int TAP_W = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // Controls
    input  wire logic             enable,
    input  wire logic             bypass,
    input  wire logic [TAP_W-1:0] taps,
    // Sample in
    input  wire logic             in_valid,
    input  wire sfc_quad_t        in_data,
    // Sample out
    output logic                  out_valid,
    output sfc_quad_t             out_data,
    output logic                  busy
);

    sfc_stage_st_t     state;
    sfc_quad_t         hist [SFC_HIST_DEPTH];
    sfc_quad_t         tap_word;
    logic [7:0]        wptr;
    logic [TAP_W-1:0]  k;
    logic [TAP_W-1:0]  taps_held;
    logic [TAP_W-1:0]  run_cnt;
    logic              take, do_pass, do_mute, do_run, do_zero, finish;

    // Request decode; bypass outranks enable
    assign take     = in_valid && (state == SFC_ST_IDLE);
    assign do_pass  = take && bypass;
    assign do_mute  = take && !bypass && !enable;
    assign do_run   = take && !bypass && enable;
    assign do_zero  = do_run && (taps == '0);
    assign finish   = (state == SFC_ST_RUN) && (k == taps_held - 1'b1);
    assign busy     = (state != SFC_ST_IDLE);
    assign tap_word = hist[8'(wptr - 8'h01 - 8'(k))];

    // History write; memory is never cleared so disable keeps it
    always_ff @(posedge clk_sys) begin
        if (do_run) begin
            hist[wptr] <= in_data;
        end
    end

    // Walk state, tap index and write pointer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state     <= SFC_ST_IDLE;
            wptr      <= 8'h00;
            k         <= '0;
            taps_held <= '0;
        end else if (do_run) begin
            wptr      <= 8'(wptr + 8'h01);
            k         <= '0;
            taps_held <= taps;
            state     <= do_zero ? SFC_ST_IDLE : SFC_ST_RUN;
        end else if (finish) begin
            state <= SFC_ST_IDLE;
        end else if (state == SFC_ST_RUN) begin
            k <= TAP_W'(k + 1'b1);
        end
    end

    // Output strobe, one cycle per accepted sample
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= do_pass || do_mute || do_zero || finish;
        end
    end

    // Per-channel accumulate and saturate
    for (genvar i = 0; i < SFC_CHANNELS; i++) begin : g_ch
        logic signed [23:0] acc;
        logic signed [23:0] sum;
        assign sum = acc + 24'(tap_word.ch[i]);
        always_ff @(posedge clk_sys) begin
            if (reset || state == SFC_ST_IDLE) begin
                acc <= '0;
            end else begin
                acc <= sum;
            end
        end
        always_ff @(posedge clk_sys) begin
            if (reset || do_mute || do_zero) begin
                out_data.ch[i] <= '0;
            end else if (do_pass) begin
                out_data.ch[i] <= in_data.ch[i];
            end else if (finish) begin
                if (sum > 24'sd32767) begin
                    out_data.ch[i] <= 16'sh7fff;
                end else if (sum < -24'sd32768) begin
                    out_data.ch[i] <= 16'sh8000;
                end else begin
                    out_data.ch[i] <= sum[15:0];
                end
            end
        end
    end

    // Helper count of walk cycles
    always_ff @(posedge clk_sys) begin
        if (reset || take) begin
            run_cnt <= '0;
        end else if (state == SFC_ST_RUN) begin
            run_cnt <= TAP_W'(run_cnt + 1'b1);
        end
    end

    chk_bypass_pass: assert property (@(posedge clk_sys) disable iff (reset)
        do_pass |=> out_valid && out_data == $past(in_data)) else $error("bypass sample altered");
    chk_disable_mute: assert property (@(posedge clk_sys) disable iff (reset)
        do_mute |=> out_valid && out_data == '0 && !busy) else $error("disabled stage not muted");
    chk_run_start: assert property (@(posedge clk_sys) disable iff (reset)
        (do_run && taps != '0) |=> busy && !out_valid) else $error("enabled stage did not run");
    chk_run_length: assert property (@(posedge clk_sys) disable iff (reset)
        finish |-> run_cnt == TAP_W'(taps_held - 1'b1)) else $error("tap walk length wrong");

endmodule
`default_nettype wire

// *** rtl/sfc_out_route.sv ***
// Output router: each audio output picks one array filter channel
`timescale 1ns/10ps
`default_nettype none
module sfc_out_route
    import sfc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Route picks, index 0 is output a
    input  wire logic [7:0] route,
    // Samples
    input  wire logic       in_valid,
    input  wire sfc_quad_t  in_data,
    output logic            out_valid,
    output sfc_quad_t       out_data
);

    // Strobe delayed one register, in step with data
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= in_valid;
        end
    end

    // One mux per output
    for (genvar i = 0; i < SFC_CHANNELS; i++) begin : g_out
        always_ff @(posedge clk_sys) begin
            if (reset) begin
                out_data.ch[i] <= '0;
            end else if (in_valid) begin
                out_data.ch[i] <= in_data.ch[route[2*i +: 2]];
            end
        end
        chk_route_pick: assert property (@(posedge clk_sys) disable iff (reset)
            in_valid |=> out_valid && out_data.ch[i] == $past(in_data.ch[route[2*i +: 2]]))
            else $error("output took wrong channel");
    end

endmodule
`default_nettype wire

// *** rtl/sfc_ctrl.sv ***
// Spatial filter control: Wishbone registers, two stages, output routing
`timescale 1ns/10ps
`default_nettype none
module sfc_ctrl
    import sfc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,

    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,

    // Audio in, four channels, same clock
    input  wire logic        smp_in_valid,
    input  wire sfc_quad_t   smp_in,

    // Audio out, outputs a to d
    output logic             smp_out_valid,
    output sfc_quad_t        smp_out,

    // Engine state
    output logic             engine_active
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sfc_setup_t  setup;
    sfc_status_t status;
    logic [31:0] setup_bits;
    logic [31:0] next_setup_bits;
    logic [15:0] out_count;
    logic [7:0]  drop_count;
    logic [7:0]  route;
    logic        req;
    logic        hit_setup;
    logic        hit_status;
    logic        setup_wr;
    logic        status_wr;
    logic        pre_valid;
    logic        pre_busy;
    logic        arr_valid;
    logic        arr_busy;
    logic        drop;
    sfc_quad_t   pre_data;
    sfc_quad_t   arr_data;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------

    // New request only while no ack is out, so each access is taken once
    assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign hit_setup  = (wb_adr_i[31:2] == SFC_SETUP_ADDR[31:2]);
    assign hit_status = (wb_adr_i[31:2] == SFC_STATUS_ADDR[31:2]);
    assign setup_wr   = req && wb_we_i && hit_setup;
    assign status_wr  = req && wb_we_i && hit_status;

    // Ack one cycle after the request is seen, dropped the next
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // ------------------------------------------------------------
    // Setup register
    // ------------------------------------------------------------

    assign setup_bits = setup;

    // Byte-lane merge of write data into the held setup word
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign next_setup_bits[8*b +: 8] =
            wb_sel_i[b] ? wb_dat_i[8*b +: 8] : setup_bits[8*b +: 8];
    end

    // Only a bus write changes setup; engine on/off never touches it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            setup <= sfc_setup_t'(SFC_SETUP_RST);
        end else if (setup_wr) begin
            setup <= sfc_setup_t'(next_setup_bits & SFC_SETUP_WMASK);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------

    // Status shows live engine state plus sample counters
    always_comb begin
        status                 = '0;
        status.out_count       = out_count;
        status.drop_count      = drop_count;
        status.engine_bypassed = setup.pre_bypass && setup.arr_bypass;
        status.engine_on       = setup.pre_enable && setup.arr_enable;
        status.arr_busy        = arr_busy;
        status.pre_busy        = pre_busy;
    end

    // Unmapped reads answer zero; reserved bits are already zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            if (hit_setup) begin
                wb_dat_o <= setup_bits;
            end else if (hit_status) begin
                wb_dat_o <= status;
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Sample counters
    // ------------------------------------------------------------

    // Count routed output samples; a status write clears, a count in
    // the same cycle still lands so no sample goes unrecorded
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_count <= 16'h0000;
        end else if (status_wr) begin
            out_count <= smp_out_valid ? 16'h0001 : 16'h0000;
        end else if (smp_out_valid) begin
            out_count <= 16'(out_count + 16'h0001);
        end
    end

    // Samples arriving while the front stage is still walking are lost
    assign drop = smp_in_valid && pre_busy;

    // Saturating drop counter so overflow cannot hide losses
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            drop_count <= 8'h00;
        end else if (status_wr) begin
            drop_count <= drop ? 8'h01 : 8'h00;
        end else if (drop && drop_count != 8'hff) begin
            drop_count <= 8'(drop_count + 8'h01);
        end
    end

    // ------------------------------------------------------------
    // Filter stages
    // ------------------------------------------------------------

    // Pre-array stage; a 7-bit tap count limits its walk
    sfc_tap_stage #(
        .TAP_W     (SFC_PRE_TAP_W)
    ) u_pre (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .enable    (setup.pre_enable),
        .bypass    (setup.pre_bypass),
        .taps      (setup.pre_tap),
        .in_valid  (smp_in_valid),
        .in_data   (smp_in),
        .out_valid (pre_valid),
        .out_data  (pre_data),
        .busy      (pre_busy)
    );

    // Array stage fed by the pre-array stage
    sfc_tap_stage #(
        .TAP_W     (SFC_ARR_TAP_W)
    ) u_arr (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .enable    (setup.arr_enable),
        .bypass    (setup.arr_bypass),
        .taps      (setup.arr_tap),
        .in_valid  (pre_valid),
        .in_data   (pre_data),
        .out_valid (arr_valid),
        .out_data  (arr_data),
        .busy      (arr_busy)
    );

    // ------------------------------------------------------------
    // Output routing
    // ------------------------------------------------------------

    // Pack picks with output a in the low bits
    assign route = {setup.out_d_route_pick, setup.out_c_route_pick,
                    setup.out_b_route_pick, setup.out_a_route_pick};

    sfc_out_route u_route (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .route     (route),
        .in_valid  (arr_valid),
        .in_data   (arr_data),
        .out_valid (smp_out_valid),
        .out_data  (smp_out)
    );

    // Engine counts as running when both stages are enabled and not both bypassed
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            engine_active <= 1'b0;
        end else begin
            engine_active <= setup.pre_enable && setup.arr_enable
                             && !(setup.pre_bypass && setup.arr_bypass);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    chk_ack_drop: assert property (@(posedge clk_sys) disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    chk_ack_follow: assert property (@(posedge clk_sys) disable iff (reset)
        req |=> wb_ack_o)
        else $error("request not acknowledged");

    chk_setup_write: assert property (@(posedge clk_sys) disable iff (reset)
        (setup_wr && wb_sel_i == 4'hf) |=> setup_bits == ($past(wb_dat_i) & SFC_SETUP_WMASK))
        else $error("setup write not stored");

    chk_setup_hold: assert property (@(posedge clk_sys) disable iff (reset)
        !setup_wr |=> $stable(setup_bits))
        else $error("setup changed without write");

    chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
        (setup_bits & SFC_RESV_MASK) == 32'h0000_0000)
        else $error("reserved setup bit set");

    chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (reset)
        (req && !wb_we_i && !hit_setup && !hit_status) |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_engine_flag: assert property (@(posedge clk_sys) disable iff (reset)
        (setup.pre_enable && setup.arr_enable && !setup.pre_bypass) |=> engine_active || setup_wr)
        else $error("engine flag missing");

    chk_full_bypass: assert property (@(posedge clk_sys) disable iff (reset)
        (setup.pre_bypass && setup.arr_bypass && !setup_wr && smp_in_valid && !pre_busy && !arr_busy)
        |=> pre_valid ##1 arr_valid && arr_data == $past(smp_in, 2))
        else $error("full bypass altered audio");

endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the spatial filter control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sfc_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk_sys;
    logic        reset;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [31:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        smp_in_valid;
    sfc_quad_t   smp_in;
    logic        smp_out_valid;
    sfc_quad_t   smp_out;
    logic        engine_active;
    sfc_quad_t   x;
    int          err_count;
    int          num_checks;
    int          cycles;

    sfc_ctrl u_dut (
        .clk_sys       (clk_sys),
        .reset         (reset),
        .wb_cyc_i      (wb_cyc_i),
        .wb_stb_i      (wb_stb_i),
        .wb_we_i       (wb_we_i),
        .wb_adr_i      (wb_adr_i),
        .wb_sel_i      (wb_sel_i),
        .wb_dat_i      (wb_dat_i),
        .wb_dat_o      (wb_dat_o),
        .wb_ack_o      (wb_ack_o),
        .smp_in_valid  (smp_in_valid),
        .smp_in        (smp_in),
        .smp_out_valid (smp_out_valid),
        .smp_out       (smp_out),
        .engine_active (engine_active)
    );

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Run needs well under a thousand cycles; ceiling leaves slack
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                           input logic [3:0] sel, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        // No local limit: only the bench ceiling may end a wait
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_sys);
    endtask

    // One sample in, cycles counted from the taking edge to the output strobe
    task automatic send(input sfc_quad_t d, output sfc_quad_t o, output int lat);
        smp_in       <= d;
        smp_in_valid <= 1'b1;
        @(posedge clk_sys);
        smp_in_valid <= 1'b0;
        lat = 0;
        do begin
            @(posedge clk_sys);
            lat++;
        end while (smp_out_valid !== 1'b1);
        o = smp_out;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Spare bits dropped, unmapped address reads zero
    task automatic test_fields();
        logic [31:0] q;
        chk("idle_engine", 64'(engine_active), 64'h0);
        wb_xfer(1'b1, SFC_SETUP_ADDR, 32'hffff_ffff, 4'hf, q);
        wb_xfer(1'b0, SFC_SETUP_ADDR, 32'h0, 4'hf, q);
        chk("setup_mask", 64'(q), 64'(SFC_SETUP_WMASK));
        chk("bypass_engine", 64'(engine_active), 64'h0);
        wb_xfer(1'b0, 32'h0000_0508, 32'h0, 4'hf, q);
        chk("unmapped", 64'(q), 64'h0);
    endtask

    // Every pick code on every output, full bypass
    task automatic test_route();
        logic [7:0]  picks [6];
        logic [31:0] q;
        sfc_quad_t   o;
        sfc_quad_t   e;
        int          lat;
        picks = '{8'he4, 8'h1b, 8'h00, 8'h55, 8'haa, 8'hff};
        foreach (picks[k]) begin
            wb_xfer(1'b1, SFC_SETUP_ADDR, {8'h30, picks[k], 16'h0000}, 4'hf, q);
            send(x, o, lat);
            for (int i = 0; i < 4; i++) begin
                e.ch[i] = x.ch[picks[k][2*i +: 2]];
            end
            chk("route", o, e);
        end
    endtask

    // Stage mixes: gain of box filter, latency, engine state
    task automatic test_configs();
        logic [31:0] cfg [5];
        int          mult [5];
        int          lat_e [5];
        logic        act [5];
        logic [31:0] q;
        sfc_quad_t   o;
        sfc_quad_t   e;
        int          lat;
        cfg   = '{32'h30e4_0102, 32'h00e4_0102, 32'h90e4_0102, 32'h60e4_0102, 32'hc0e4_0102};
        mult  = '{1, 0, 2, 1, 2};
        lat_e = '{3, 3, 5, 4, 6};
        act   = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        foreach (cfg[k]) begin
            wb_xfer(1'b1, SFC_SETUP_ADDR, cfg[k], 4'hf, q);
            // Three equal samples fill both histories before judging
            repeat (3) send(x, o, lat);
            for (int i = 0; i < 4; i++) begin
                e.ch[i] = sfc_sample_t'(mult[k] * x.ch[i]);
            end
            chk("samples", o, e);
            chk("latency", 64'(lat), 64'(lat_e[k]));
            chk("engine", 64'(engine_active), 64'(act[k]));
        end
    endtask

    // Enables cleared by top lane only; fields and history survive
    task automatic test_resume();
        logic [31:0] q;
        sfc_quad_t   o;
        sfc_quad_t   e;
        int          lat;
        wb_xfer(1'b1, SFC_SETUP_ADDR, 32'h0000_0000, 4'h8, q);
        wb_xfer(1'b0, SFC_SETUP_ADDR, 32'h0, 4'hf, q);
        chk("kept_setup", 64'(q), 64'h00e4_0102);
        chk("stopped", 64'(engine_active), 64'h0);
        wb_xfer(1'b1, SFC_SETUP_ADDR, 32'hc000_0000, 4'h8, q);
        send(x, o, lat);
        for (int i = 0; i < 4; i++) begin
            e.ch[i] = sfc_sample_t'(2 * x.ch[i]);
        end
        chk("resumed", o, e);
    endtask

    // Status: a write clears both counts; a back-to-back pair loses its second sample
    task automatic test_status();
        logic [31:0] q;
        sfc_quad_t   o;
        int          lat;
        wb_xfer(1'b1, SFC_STATUS_ADDR, 32'h0, 4'hf, q);
        smp_in       <= x;
        smp_in_valid <= 1'b1;
        @(posedge clk_sys);
        send(x, o, lat);
        wb_xfer(1'b0, SFC_STATUS_ADDR, 32'h0, 4'hf, q);
        chk("status", 64'(q), 64'h0001_0104);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        err_count    = 0;
        num_checks   = 0;
        cycles       = 0;
        reset        = 1'b1;
        wb_cyc_i     = 1'b0;
        wb_stb_i     = 1'b0;
        wb_we_i      = 1'b0;
        wb_adr_i     = 32'h0;
        wb_sel_i     = 4'h0;
        wb_dat_i     = 32'h0;
        smp_in_valid = 1'b0;
        smp_in       = '0;
        x.ch[0]      = 16'h0064;
        x.ch[1]      = 16'hff38;
        x.ch[2]      = 16'h012c;
        x.ch[3]      = 16'hfe70;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        test_fields();
        test_route();
        test_configs();
        test_resume();
        test_status();
        test_done();
    end
endmodule
`default_nettype wire
